/* rtl/gpd_pkg.sv */
//------------------------------------------------------------------------------
// Purpose: Shared constants for the gate pattern and two-speed capture block.
// Assumes: 200 MHz system clock, AXI4-Lite register access with 32-bit data.
// Notes:   Offsets are byte addresses, one aligned word per register.
//------------------------------------------------------------------------------
package gpd_pkg;

   // -------------------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 5;
   localparam int TICK_PERIOD_NS = 1000;
   localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // -------------------------------------------------------------------------
   // Register map
   // -------------------------------------------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_GATE = 8'h04;
   localparam logic [7:0] REG_MASTER = 8'h08;
   localparam logic [7:0] REG_SLOW = 8'h0C;
   localparam logic [7:0] REG_DESC = 8'h10;
   localparam logic [7:0] REG_STATUS = 8'h14;
   localparam logic [7:0] REG_RATEMAP = 8'h18;
   localparam logic [7:0] REG_TS_LAST = 8'h1C;
   localparam logic [7:0] REG_TS_COUNT = 8'h20;

   // -------------------------------------------------------------------------
   // Field layout and values
   // -------------------------------------------------------------------------
   localparam int DESC_COUNT_W = 28;
   localparam int PAT_W = 4;
   localparam int GATE_LINES = 6;
   localparam logic [7:0] SLOW_DIV_MAX = 8'h80;
   localparam logic [7:0] SLOW_DIV_RST = 8'h04;
   localparam logic [7:0] SLOW_SHIFT_RST = 8'hFE;
   localparam logic [31:0] RATE_MARKER = 32'hE5E5_0000;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef enum logic [1:0] {MODE_IDLE, MODE_GATED, MODE_TWO_SPEED, MODE_MULTI} gpd_mode_type;

endpackage

/* rtl/gpd_axil_port.sv */
//------------------------------------------------------------------------------
// Purpose: AXI4-Lite slave front end; turns bus transfers into strobes.
// Assumes: One write and one read outstanding at most.
// Notes:   Write address and data may arrive in either order.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module gpd_axil_port
   import gpd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite write channels
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   // AXI4-Lite read channels
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Register side
   output logic wrEn,
   output logic [7:0] wrAddr,
   output logic [31:0] wrData,
   output logic [3:0] wrStrb,
   input wire logic wrOk,
   output logic rdEn,
   output logic [7:0] rdAddr,
   input wire logic rdOk
);

   typedef struct packed {
      logic awFull;
      logic [7:0] aw;
      logic wFull;
      logic [31:0] wd;
      logic [3:0] ws;
      logic bv;
      logic [1:0] br;
      logic rv;
      logic [1:0] rr;
   } gpd_port_type;

   gpd_port_type s_r;
   gpd_port_type s_nxt;

   assign awready = !s_r.awFull;
   assign wready = !s_r.wFull;
   assign arready = !s_r.rv;
   assign bvalid = s_r.bv;
   assign bresp = s_r.br;
   assign rvalid = s_r.rv;
   assign rresp = s_r.rr;
   assign wrEn = s_r.awFull && s_r.wFull && !s_r.bv;
   assign wrAddr = s_r.aw;
   assign wrData = s_r.wd;
   assign wrStrb = s_r.ws;
   assign rdEn = arvalid && !s_r.rv;
   assign rdAddr = araddr;

   always_comb
   begin
      s_nxt = s_r;
      if (awvalid && !s_r.awFull)
      begin
         s_nxt.awFull = 1'b1;
         s_nxt.aw = awaddr;
      end
      if (wvalid && !s_r.wFull)
      begin
         s_nxt.wFull = 1'b1;
         s_nxt.wd = wdata;
         s_nxt.ws = wstrb;
      end
      if (wrEn)
      begin
         s_nxt.bv = 1'b1;
         s_nxt.br = wrOk ? RESP_OKAY : RESP_SLVERR;
      end
      if (s_r.bv && bready)
      begin
         s_nxt.bv = 1'b0;
         s_nxt.awFull = 1'b0;
         s_nxt.wFull = 1'b0;
      end
      if (rdEn)
      begin
         s_nxt.rv = 1'b1;
         s_nxt.rr = rdOk ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_r.rv && rready)
      begin
         s_nxt.rv = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule

/* rtl/gpd_top.sv */
//------------------------------------------------------------------------------
// Purpose: Gate pulse pattern generator, gated and two-speed capture control,
//          and nanosecond timebase for gated captures.
// Assumes: Sample strobes are synchronous to clk and come no faster than one
//          every other cycle in two-speed mode.
// Notes:   Registers are reached over AXI4-Lite through gpd_axil_port.
//------------------------------------------------------------------------------
`timescale 1ns/1ps

// Functional notes
// - Gated mode keeps samples only while gate active.
// - One 32-bit nanosecond timestamp per gated sample.
// - Timestamp spans about four seconds, no wider.
// - Timebase is a separate record after shot; here one stamp leaves beside each gated sample, in the same cycle.
// - Generator drives a four-bit pattern from descriptors.
// - Descriptor state reached after its tick count.
// - Descriptor tick count is 28 bits.
// - Ticks come from the internal tick clock.
// - Microsecond tick lets one descriptor last 268 s.
// - Descriptors stream in order without length limit.
// - Pattern bits map to lines four to seven.
// - Master selection picks driven lines; none disables.
// - Selected lines start at a programmable level.
// - Two-speed: fast while gate active, slow otherwise.
// - Slow rate decimates sample clock, divisor to 128.
// - Slow path applies a signed scaling shift.
// - Marker word inserted at every rate change.
// - Gate from input lines zero-five, selectable polarity.
// - Capture path sustains 128 MB/s aggregate.
// - Multi-rate allowed only with 32 MHz base clock.
// - Multi-rate output stays raw and interleaved.
module gpd_top
   import gpd_pkg::*;
#(
   parameter int SAMPLE_W = 16,
   parameter int TICK_DIV = TICK_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // AXI4-Lite register bus
   input wire logic [7:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic [7:0] araddr,
   input wire logic arvalid,
   output logic arready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   // Digital input lines and pattern outputs (bit 0 is line four)
   input wire logic [GATE_LINES-1:0] digitalInputLine,
   output logic [PAT_W-1:0] patternOut,
   output logic [PAT_W-1:0] patternEnN,
   // Raw sample stream in
   input wire logic sampleValid,
   input wire logic [SAMPLE_W-1:0] sampleData,
   // Capture stream out
   output logic capValid,
   output logic [31:0] capData,
   output logic capMarker,
   // Timebase record out
   output logic tbValid,
   output logic [31:0] tbData
);

   // -------------------------------------------------------------------------
   // State
   // -------------------------------------------------------------------------
   typedef struct packed {
      gpd_mode_type mode;
      logic run;
      logic base32;
      logic [2:0] gateSel;
      logic gateLow;
      logic [PAT_W-1:0] masSel;
      logic [PAT_W-1:0] masInit;
      logic [7:0] divisor;
      logic [7:0] shift;
      logic [31:0] rateMap;
      logic descFull;
      logic [PAT_W-1:0] descState;
      logic [DESC_COUNT_W-1:0] descCount;
      logic active;
      logic [PAT_W-1:0] target;
      logic [DESC_COUNT_W-1:0] tickCnt;
      logic [PAT_W-1:0] pattern;
      logic [15:0] tickDiv;
      logic tick;
      logic fast;
      logic [7:0] decimCnt;
      logic pendValid;
      logic [SAMPLE_W-1:0] pendData;
      logic [31:0] nsCnt;
      logic [31:0] tsLast;
      logic [31:0] tsCount;
      logic capValid;
      logic [31:0] capData;
      logic capMarker;
      logic tbValid;
      logic [31:0] tbData;
      logic [31:0] rdData;
   } gpd_state_type;

   gpd_state_type s_r;
   gpd_state_type s_nxt;

   logic wrEn;
   logic [7:0] wrAddr;
   logic [31:0] wrData;
   logic [3:0] wrStrb;
   logic wrOk;
   logic rdEn;
   logic [7:0] rdAddr;
   logic rdOk;
   logic gateActive;

   // -------------------------------------------------------------------------
   // Bus front end
   // -------------------------------------------------------------------------
   gpd_axil_port u_port (
      .clk(clk),
      .resetn(resetn),
      .awaddr(awaddr),
      .awvalid(awvalid),
      .awready(awready),
      .wdata(wdata),
      .wstrb(wstrb),
      .wvalid(wvalid),
      .wready(wready),
      .bresp(bresp),
      .bvalid(bvalid),
      .bready(bready),
      .araddr(araddr),
      .arvalid(arvalid),
      .arready(arready),
      .rresp(rresp),
      .rvalid(rvalid),
      .rready(rready),
      .wrEn(wrEn),
      .wrAddr(wrAddr),
      .wrData(wrData),
      .wrStrb(wrStrb),
      .wrOk(wrOk),
      .rdEn(rdEn),
      .rdAddr(rdAddr),
      .rdOk(rdOk)
   );

   assign wrOk = (wrAddr == REG_CTRL) || (wrAddr == REG_GATE) || (wrAddr == REG_MASTER) ||
      (wrAddr == REG_SLOW) || (wrAddr == REG_DESC) || (wrAddr == REG_RATEMAP);
   assign rdOk = (rdAddr <= REG_TS_COUNT) && (rdAddr[1:0] == 2'b00);

   // -------------------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------------------
   assign rdata = s_r.rdData;
   assign patternOut = s_r.pattern & s_r.masSel;
   assign patternEnN = ~s_r.masSel;
   assign capValid = s_r.capValid;
   assign capData = s_r.capData;
   assign capMarker = s_r.capMarker;
   assign tbValid = s_r.tbValid;
   assign tbData = s_r.tbData;

   // Lines above five never count as an active gate.
   assign gateActive = (s_r.gateSel < 3'(GATE_LINES)) &&
      (digitalInputLine[s_r.gateSel] ^ s_r.gateLow);

   // -------------------------------------------------------------------------
   // Next state
   // -------------------------------------------------------------------------
   always_comb
   begin
      logic sv;
      logic [SAMPLE_W-1:0] sd;
      logic signed [31:0] ext;
      logic signed [7:0] sh;
      logic [7:0] shAbs;
      logic gatedMode;
      sv = 1'b0;
      sd = '0;
      ext = '0;
      sh = '0;
      shAbs = '0;
      gatedMode = 1'b0;
      s_nxt = s_r;
      s_nxt.capValid = 1'b0;
      s_nxt.capMarker = 1'b0;
      s_nxt.tbValid = 1'b0;

      // Register writes.
      if (wrEn && wrStrb[0])
      begin
         case (wrAddr)
            REG_CTRL:
            begin
               s_nxt.mode = gpd_mode_type'(wrData[1:0]);
               s_nxt.run = wrData[2];
               s_nxt.base32 = wrData[3];
            end
            REG_GATE:
            begin
               s_nxt.gateSel = wrData[2:0];
               s_nxt.gateLow = wrData[3];
            end
            REG_MASTER:
            begin
               s_nxt.masSel = wrData[3:0];
               s_nxt.masInit = wrData[7:4];
            end
            REG_SLOW:
            begin
               // Divisor is clamped so a zero write cannot stall the slow path.
               if (wrData[7:0] == 8'h00)
               begin
                  s_nxt.divisor = 8'h01;
               end
               else if (wrData[7:0] > SLOW_DIV_MAX)
               begin
                  s_nxt.divisor = SLOW_DIV_MAX;
               end
               else
               begin
                  s_nxt.divisor = wrData[7:0];
               end
               s_nxt.shift = wrData[15:8];
            end
            default:
            begin
            end
         endcase
      end
      if (wrEn && (wrAddr == REG_RATEMAP))
      begin
         s_nxt.rateMap = wrData;
      end
      // A descriptor written while the slot is full is refused; software
      // polls the slot flag so the stream itself has no length limit.
      if (wrEn && (wrAddr == REG_DESC) && !s_r.descFull)
      begin
         s_nxt.descFull = 1'b1;
         s_nxt.descState = wrData[31:28];
         s_nxt.descCount = wrData[27:0];
      end

      // Internal tick clock divider.
      s_nxt.tick = 1'b0;
      if (s_r.tickDiv >= 16'(TICK_DIV - 1))
      begin
         s_nxt.tickDiv = '0;
         s_nxt.tick = 1'b1;
      end
      else
      begin
         s_nxt.tickDiv = s_r.tickDiv + 16'h0001;
      end

      // Pattern generator.
      if (!s_r.run)
      begin
         s_nxt.active = 1'b0;
         s_nxt.tickCnt = '0;
         s_nxt.pattern = s_r.masInit;
      end
      else if (s_r.active)
      begin
         if (s_r.tick)
         begin
            // 28-bit count of 1 us ticks reaches about 268 s.
            if (s_r.tickCnt <= 28'h0000001)
            begin
               s_nxt.pattern = s_r.target;
               s_nxt.active = 1'b0;
            end
            else
            begin
               s_nxt.tickCnt = s_r.tickCnt - 28'h0000001;
            end
         end
      end
      else if (s_r.descFull && !(wrEn && (wrAddr == REG_DESC)))
      begin
         s_nxt.descFull = 1'b0;
         s_nxt.active = 1'b1;
         s_nxt.target = s_r.descState;
         s_nxt.tickCnt = s_r.descCount;
      end
      // With no descriptor pending the pattern register simply keeps its
      // value.

      // Nanosecond timebase, cleared while idle so each shot starts at zero.
      // It wraps after about 4.29 s.
      if (s_r.mode == MODE_IDLE)
      begin
         s_nxt.nsCnt = '0;
      end
      else
      begin
         s_nxt.nsCnt = s_r.nsCnt + 32'(CLK_PERIOD_NS);
      end

      // Capture paths; the output takes one word per clock, far above the
      // 128 MB/s aggregate.
      ext = 32'(signed'(sampleData));
      case (s_r.mode)
         MODE_GATED:
         begin
            gatedMode = 1'b1;
            if (sampleValid && gateActive)
            begin
               s_nxt.capValid = 1'b1;
               s_nxt.capData = ext;
               s_nxt.tbValid = 1'b1;
               s_nxt.tbData = s_r.nsCnt;
               s_nxt.tsLast = s_r.nsCnt;
               s_nxt.tsCount = s_r.tsCount + 32'h0000_0001;
            end
         end
         MODE_TWO_SPEED:
         begin
            sv = s_r.pendValid || sampleValid;
            sd = s_r.pendValid ? s_r.pendData : sampleData;
            s_nxt.pendValid = s_r.pendValid && sampleValid;
            s_nxt.pendData = sampleData;
            ext = 32'(signed'(sd));
            s_nxt.fast = gateActive;
            if (gateActive != s_r.fast)
            begin
               // Marker takes the slot; a sample this cycle waits one cycle.
               s_nxt.capValid = 1'b1;
               s_nxt.capMarker = 1'b1;
               s_nxt.capData = RATE_MARKER | 32'(gateActive);
               s_nxt.decimCnt = '0;
               s_nxt.pendValid = sv;
               s_nxt.pendData = sd;
            end
            else if (sv && s_r.fast)
            begin
               s_nxt.capValid = 1'b1;
               s_nxt.capData = ext;
            end
            else if (sv)
            begin
               if (s_r.decimCnt == 8'h00)
               begin
                  sh = signed'(s_r.shift);
                  shAbs = 8'(-sh);
                  s_nxt.capValid = 1'b1;
                  s_nxt.capData = sh[7] ? 32'(ext <<< shAbs) : 32'(ext >>> s_r.shift);
                  s_nxt.decimCnt = s_r.divisor - 8'h01;
               end
               else
               begin
                  s_nxt.decimCnt = s_r.decimCnt - 8'h01;
               end
            end
         end
         MODE_MULTI:
         begin
            // Words leave in arrival order; demultiplexing is left to the host.
            if (sampleValid && s_r.base32)
            begin
               s_nxt.capValid = 1'b1;
               s_nxt.capData = ext;
            end
         end
         default:
         begin
            s_nxt.fast = 1'b0;
            s_nxt.pendValid = 1'b0;
         end
      endcase
      if (!gatedMode && (s_r.mode != MODE_IDLE))
      begin
         s_nxt.tbValid = 1'b0;
      end
      if (wrEn && (wrAddr == REG_CTRL) && (wrData[1:0] == 2'(MODE_GATED)) &&
         (s_r.mode != MODE_GATED))
      begin
         s_nxt.tsCount = '0;
      end

      // Register reads.
      if (rdEn)
      begin
         case (rdAddr)
            REG_CTRL:
               s_nxt.rdData = {28'h0, s_r.base32, s_r.run, 2'(s_r.mode)};
            REG_GATE:
               s_nxt.rdData = {28'h0, s_r.gateLow, s_r.gateSel};
            REG_MASTER:
               s_nxt.rdData = {24'h0, s_r.masInit, s_r.masSel};
            REG_SLOW:
               s_nxt.rdData = {16'h0, s_r.shift, s_r.divisor};
            REG_STATUS:
               s_nxt.rdData = {24'h0, s_r.pattern, s_r.fast, gateActive, s_r.active,
                  s_r.descFull};
            REG_RATEMAP:
               s_nxt.rdData = s_r.rateMap;
            REG_TS_LAST:
               s_nxt.rdData = s_r.tsLast;
            REG_TS_COUNT:
               s_nxt.rdData = s_r.tsCount;
            default:
               s_nxt.rdData = 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // State register
   // -------------------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         s_r <= '0;
         s_r.divisor <= SLOW_DIV_RST;
         s_r.shift <= SLOW_SHIFT_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

endmodule

/* verification/gpd_top_properties.sv */
// Purpose: Port-level checks on gpd_top, attached by bind.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Timestamp step of ten assumes samples two cycles apart.
`timescale 1ns/1ps
module gpd_top_props
   import gpd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Register bus
   input wire logic awready,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   // Pattern and capture
   input wire logic [PAT_W-1:0] patternOut,
   input wire logic [PAT_W-1:0] patternEnN,
   input wire logic sampleValid,
   input wire logic capValid,
   input wire logic [31:0] capData,
   input wire logic capMarker,
   input wire logic tbValid,
   input wire logic [31:0] tbData
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);
   // ----------
   // Assertions
   // ----------
   a_lines_undriven:
      assert property ((patternOut & patternEnN) == 4'h0)
      else $error("Pattern drives a deselected line.");
   a_marker_word:
      assert property (capMarker |-> capValid && capData[31:1] == RATE_MARKER[31:1])
      else $error("Marker word malformed.");
   a_cap_cause:
      assert property (capValid && !capMarker |-> $past(sampleValid) || $past(sampleValid, 2))
      else $error("Captured word without a sample.");
   a_stamp_cause:
      assert property (tbValid |-> capValid && $past(sampleValid))
      else $error("Timestamp without a captured sample.");
   a_stamp_step:
      assert property (tbValid ##2 tbValid |-> tbData == $past(tbData, 2) + 32'h0000000A)
      else $error("Timestamp step is not ten nanoseconds.");
   a_write_block:
      assert property (bvalid |-> !awready && !wready)
      else $error("Write channels open while response pending.");
   a_read_block:
      assert property (rvalid |-> !arready)
      else $error("Read address open while data pending.");
   a_read_once:
      assert property (rvalid && rready |=> !rvalid)
      else $error("Read data repeated after handshake.");
   c_marker: cover property (capMarker);
   c_stamp_run: cover property (tbValid ##2 tbValid);
   c_partial: cover property (patternEnN == 4'hC && patternOut != 4'h0);
endmodule
bind gpd_top gpd_top_props u_gpd_top_props (.clk, .resetn, .awready, .wready, .bvalid, .arready,
   .rvalid, .rready, .patternOut, .patternEnN, .sampleValid, .capValid, .capData, .capMarker,
   .tbValid, .tbData);

/* verification/gpd_sample_src.sv */
// Purpose: Raw sample source standing in for the acquisition front end.
// Assumes: Strobes every other cycle, the closest spacing accepted.
// Notes:   Data lines show the inverse of the last word between strobes.
`timescale 1ns/1ps
module gpd_sample_src
(
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Control
   input wire logic run,
   // Sample stream
   output logic sampleValid,
   output logic [15:0] sampleData
);
   logic [15:0] count_r;
   always @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         sampleValid <= 1'b0;
         sampleData <= 16'h0000;
         count_r <= 16'hFFF0;
      end
      else
      begin
         sampleValid <= run && !sampleValid;
         if (run && !sampleValid)
         begin
            sampleData <= count_r;
            count_r <= count_r + 16'h0001;
         end
         else
            sampleData <= ~sampleData;
      end
   end
endmodule

/* verification/tb.sv */
// Purpose: Self-checking bench for gpd_top through its register bus.
// Assumes: TICK_DIV of 4 keeps pattern timing short.
// Notes:   Data checks run only inside counting windows, away from rate changes.
`timescale 1ns/1ps
module tb
   import gpd_pkg::*;
;
   logic clk, resetn, awvalid, wvalid, bready, arvalid, rready, sampleRun, slowPh, chkOn;
   logic awready, wready, bvalid, arready, rvalid, sampleValid, capValid, capMarker, tbValid;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, capData, tbData, lastTb;
   logic [3:0] wstrb, patternOut, patternEnN;
   logic [1:0] bresp, rresp;
   logic [5:0] digitalInputLine;
   logic [15:0] sampleData;
   logic signed [15:0] last;
   logic [31:0] mk[$];
   int fails, checked, nCap, nSmp, nTb, i;
   gpd_top #(.TICK_DIV(4)) u_gpd_top (.clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
      .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
      .rvalid, .rready, .digitalInputLine, .patternOut, .patternEnN, .sampleValid, .sampleData,
      .capValid, .capData, .capMarker, .tbValid, .tbData);
   gpd_sample_src u_gpd_sample_src (.clk, .resetn, .run(sampleRun), .sampleValid, .sampleData);
   initial
   begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic wrChk(input logic [7:0] a, input logic [31:0] dd, input logic [1:0] er);
      int n;
      @(posedge clk);
      awaddr <= a;
      wdata <= dd;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      bready <= 1'b0;
      chk({30'h0, bresp}, {30'h0, er});
      if (n == 64) fails++;
   endtask
   task automatic rdChk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      int n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      rready <= 1'b0;
      chk(rdata, e);
      chk({30'h0, rresp}, {30'h0, er});
      if (n == 64) fails++;
   endtask
   // Counting windows are cut on falling edges so they never race the monitor.
   task automatic window(input int n);
      @(negedge clk);
      nCap = 0;
      nSmp = 0;
      chkOn = 1'b1;
      repeat (n) @(negedge clk);
      chkOn = 1'b0;
   endtask
   always @(posedge clk)
   begin
      if (capValid && capMarker)
      begin
         mk.push_back(capData);
         slowPh = !capData[0];
      end
      else if (capValid)
      begin
         nCap++;
         if (chkOn) chk(capData, slowPh ? 32'(last) <<< 2 : 32'(last));
      end
      if (tbValid)
      begin
         nTb++;
         lastTb = tbData;
      end
      if (sampleValid)
      begin
         nSmp++;
         last = sampleData;
      end
   end
   initial
   begin
      repeat (20000) @(posedge clk);
      fails++;
      conclude();
   end
   // -----
   // Tests
   // -----
   initial
   begin
      resetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, sampleRun, slowPh, chkOn} = 8'h00;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wstrb = 4'hF;
      digitalInputLine = 6'h00;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      rdChk(REG_CTRL, 32'h0, RESP_OKAY);
      rdChk(REG_MASTER, 32'h0, RESP_OKAY);
      rdChk(REG_SLOW, 32'h0000FE04, RESP_OKAY);
      rdChk(8'h3C, 32'h0, RESP_SLVERR);
      wrChk(REG_STATUS, 32'h1, RESP_SLVERR);
      chk(32'(patternEnN), 32'hF);
      $display("test registers done");
      wrChk(REG_MASTER, 32'h5F, RESP_OKAY);
      wrChk(REG_CTRL, 32'h4, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'(patternOut), 32'h5);
      chk(32'(patternEnN), 32'h0);
      wrChk(REG_DESC, 32'h90000003, RESP_OKAY);
      wrChk(REG_DESC, 32'h60000005, RESP_OKAY);
      chk(32'(patternOut), 32'h5);
      repeat (12) @(posedge clk);
      chk(32'(patternOut), 32'h9);
      repeat (40) @(posedge clk);
      chk(32'(patternOut), 32'h6);
      wrChk(REG_MASTER, 32'h03, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'({patternEnN, patternOut}), 32'hC2);
      wrChk(REG_MASTER, 32'h00, RESP_OKAY);
      repeat (2) @(posedge clk);
      chk(32'({patternEnN, patternOut}), 32'hF0);
      $display("test pattern done");
      sampleRun <= 1'b1;
      for (i = 0; i < 2; i++)
      begin
         wrChk(REG_CTRL, 32'h0, RESP_OKAY);
         wrChk(REG_GATE, 32'(2 + 8 * i), RESP_OKAY);
         digitalInputLine <= i ? 6'h04 : 6'h00;
         slowPh = 1'b0;
         nTb = 0;
         wrChk(REG_CTRL, 32'h1, RESP_OKAY);
         window(20);
         chk(32'(nCap), 32'h0);
         @(posedge clk);
         digitalInputLine <= i ? 6'h00 : 6'h04;
         repeat (6) @(posedge clk);
         window(40);
         chk(32'(nSmp), 32'h14);
         chk(32'(nCap), 32'(nSmp));
         @(posedge clk);
         digitalInputLine <= i ? 6'h04 : 6'h00;
         repeat (6) @(posedge clk);
         rdChk(REG_TS_COUNT, 32'(nTb), RESP_OKAY);
         rdChk(REG_TS_LAST, lastTb, RESP_OKAY);
         wrChk(REG_CTRL, 32'(3 + 8 * i), RESP_OKAY);
         window(20);
         chk(32'(nCap), i ? 32'hA : 32'h0);
      end
      $display("test gated done");
      wrChk(REG_CTRL, 32'h0, RESP_OKAY);
      wrChk(REG_GATE, 32'h2, RESP_OKAY);
      digitalInputLine <= 6'h00;
      slowPh = 1'b1;
      wrChk(REG_CTRL, 32'h2, RESP_OKAY);
      repeat (20) @(posedge clk);
      mk.delete();
      digitalInputLine <= 6'h04;
      repeat (10) @(posedge clk);
      window(64);
      chk(32'(nCap), 32'(nSmp));
      @(posedge clk);
      digitalInputLine <= 6'h00;
      for (i = 0; i < 2; i++)
      begin
         wrChk(REG_SLOW, i ? 32'h0000FE90 : 32'h0000FE04, RESP_OKAY);
         repeat (600) @(posedge clk);
         window(i ? 2048 : 64);
         chk(32'(nCap), 32'h8);
      end
      chk(32'(mk.size()), 32'h2);
      chk(mk[0], RATE_MARKER | 32'h1);
      chk(mk[1], RATE_MARKER);
      $display("test two-speed done");
      conclude();
   end
endmodule
